// ---- verilog/cgis_pkg.sv ----
// Package with constants, layouts and types of the clock guard and integrity status block.
`default_nettype none

package cgis_pkg;

  // ------------------------------------------------------------------
  // Bus map
  // ------------------------------------------------------------------
  localparam logic [1:0] ICS_ADDR = 2'h0;
  localparam logic [7:0] ICS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Main clock counts as lost after this time without an edge.
  localparam int MISS_TIME_NS = 2000;
  localparam logic [7:0] MISS_CYC =
    8'((MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Shortest level of the main clock that passes the spike filter.
  // It must exceed the two cycles that the pin voting already demands,
  // or the filter would reject nothing that the synchroniser lets by.
  localparam int FILT_TIME_NS = 100;
  localparam logic [3:0] FILT_CYC =
    4'((FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Clean main clock edges needed before leaving the safe clock.
  localparam logic [3:0] RECOVER_EDGES = 4'h8;

  // ------------------------------------------------------------------
  // Pin synchroniser slots
  // ------------------------------------------------------------------
  localparam int SYNC_W = 4;
  localparam int SY_MAIN = 0;
  localparam int SY_SAFE = 1;
  localparam int SY_VDD = 2;
  localparam int SY_PIN = 3;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic monitor_source_select;
    logic supply_monitor_irq_enable;
    logic supply_monitor_flag;
    logic undervoltage_reset_flag;
    logic reserved;
    logic clock_fail_irq_enable;
    logic safe_clock_active_flag;
    logic watchdog_reset_flag;
  } cgis_ics_t;

  typedef enum logic [1:0] {
    CG_OFF = 2'b00,
    CG_MAIN = 2'b01,
    CG_SAFE = 2'b10
  } cgis_guard_state_t;

  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_WDG = 2'b01,
    SRC_UV = 2'b10
  } cgis_reset_src_t;

endpackage

`default_nettype wire

// ---- verilog/cgis_clk_switch.sv ----
// Glitch-free switch between the main and the safe clock levels.
`timescale 1ns/1ps
`default_nettype none

module cgis_clk_switch (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic main_lvl_i,
  input wire logic safe_lvl_i,
  input wire logic use_safe_i,
  input wire logic main_dead_i,
  input wire logic stop_i,
  output logic clk_o,
  output logic on_safe_o
);

  logic out_reg;
  logic out_next;
  logic sel_reg;
  logic sel_next;
  logic pending;
  logic cur_lvl;
  logic new_lvl;
  logic hold;

  // ------------------------------------------------------------------
  // Switch control
  // ------------------------------------------------------------------
  // The output is parked low before the source changes, and the new
  // source is taken only while it is low, so no pulse is cut short.
  // A dead main clock stuck high is forced low; that one high phase
  // is the price of leaving a clock that will never fall.
  always_comb begin
    pending = use_safe_i != sel_reg;
    cur_lvl = sel_reg ? safe_lvl_i : main_lvl_i;
    new_lvl = sel_reg ? main_lvl_i : safe_lvl_i;
    hold = sel_reg | ~main_dead_i;
    sel_next = sel_reg;
    out_next = cur_lvl;
    if (stop_i) begin
      out_next = 1'b0;
    end else if (pending) begin
      out_next = out_reg & cur_lvl & hold;
      if (!out_reg && !new_lvl) begin
        sel_next = use_safe_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      sel_reg <= sel_next;
    end
  end

  assign clk_o = out_reg;
  assign on_safe_o = sel_reg;

endmodule

`default_nettype wire

// ---- verilog/cgis_top.sv ----
// Clock guard with safe clock fallback and the integrity control/status register.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module cgis_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [1:0] wb_adr_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic main_osc_i,
  input wire logic safe_osc_i,
  input wire logic supply_cmp_vdd_i,
  input wire logic supply_cmp_pin_i,
  input wire logic pll_enable_i,
  input wire logic css_option_i,
  input wire logic lvd_option_i,
  input wire logic halt_i,
  input wire logic wait_i,
  input wire logic global_mask_i,
  input wire logic supply_irq_ack_i,
  input wire logic ext_reset_i,
  input wire logic wdg_reset_i,
  input wire logic lvd_reset_i,
  output logic processor_clock_o,
  output logic safe_osc_enable_o,
  output logic safe_clock_active_o,
  output logic clock_fail_irq_o,
  output logic supply_irq_o,
  output logic wake_o,
  output logic [1:0] reset_source_o
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [cgis_pkg::SYNC_W-1:0] s1_reg;
  logic [cgis_pkg::SYNC_W-1:0] s2_reg;
  logic [cgis_pkg::SYNC_W-1:0] s3_reg;
  logic [cgis_pkg::SYNC_W-1:0] lvl_reg;
  logic [cgis_pkg::SYNC_W-1:0] lvl_next;

  logic filt_reg;
  logic filt_next;
  logic [3:0] filt_cnt_reg;
  logic [3:0] filt_cnt_next;
  logic main_edge;

  cgis_pkg::cgis_guard_state_t state_reg;
  cgis_pkg::cgis_guard_state_t state_next;
  logic [7:0] miss_reg;
  logic [7:0] miss_next;
  logic [3:0] edges_reg;
  logic [3:0] edges_next;
  logic main_dead;
  logic chip_reset;
  logic clk_lvl;
  logic on_safe;

  cgis_pkg::cgis_ics_t ics_reg;
  cgis_pkg::cgis_ics_t ics_next;
  cgis_pkg::cgis_ics_t wdat;
  logic pend_reg;
  logic pend_next;
  logic ack_reg;
  logic ack_next;
  logic [7:0] dat_reg;
  logic [7:0] dat_next;
  logic bus_take;
  logic hit;
  logic wr_take;
  logic rd_take;
  logic supply_sel;
  logic toggle;
  logic ie_rise;

  logic proc_clk_reg;
  logic safe_en_reg;
  logic safe_act_reg;
  logic cf_irq_reg;
  logic cf_irq_next;
  logic sm_irq_reg;
  logic sm_irq_next;
  logic wake_reg;
  logic wake_next;
  logic [1:0] src_reg;
  logic [1:0] src_next;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // A level is taken only when the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < cgis_pkg::SYNC_W; gi++) begin : g_sync
      logic pin;
      always_comb begin
        case (gi)
          cgis_pkg::SY_MAIN: pin = main_osc_i;
          cgis_pkg::SY_SAFE: pin = safe_osc_i;
          cgis_pkg::SY_VDD: pin = supply_cmp_vdd_i;
          default: pin = supply_cmp_pin_i;
        endcase
        lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : lvl_reg[gi];
      end
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          lvl_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pin;
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          lvl_reg[gi] <= lvl_next[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Main clock spike filter
  // ------------------------------------------------------------------
  // With the PLL on, a new level must stand for the minimum time
  // before it is accepted; without it the level passes directly.
  always_comb begin
    filt_next = filt_reg;
    filt_cnt_next = 4'h0;
    if (!pll_enable_i) begin
      filt_next = lvl_reg[cgis_pkg::SY_MAIN];
    end else if (lvl_reg[cgis_pkg::SY_MAIN] != filt_reg) begin
      filt_cnt_next = filt_cnt_reg + 4'h1;
      if (filt_cnt_next >= cgis_pkg::FILT_CYC) begin
        filt_next = lvl_reg[cgis_pkg::SY_MAIN];
        filt_cnt_next = 4'h0;
      end
    end
    main_edge = filt_next != filt_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      filt_reg <= 1'b0;
      filt_cnt_reg <= 4'h0;
    end else begin
      filt_reg <= filt_next;
      filt_cnt_reg <= filt_cnt_next;
    end
  end

  // ------------------------------------------------------------------
  // Clock guard
  // ------------------------------------------------------------------
  assign chip_reset = ext_reset_i | wdg_reset_i | lvd_reset_i;
  assign main_dead = miss_reg == cgis_pkg::MISS_CYC;

  always_comb begin
    state_next = state_reg;
    miss_next = miss_reg;
    edges_next = edges_reg;
    if (chip_reset) begin
      state_next = css_option_i ? cgis_pkg::CG_MAIN : cgis_pkg::CG_OFF;
      miss_next = 8'h00;
      edges_next = 4'h0;
    end else if (halt_i) begin
      state_next = state_reg;
    end else begin
      if (main_edge) begin
        miss_next = 8'h00;
      end else if (!main_dead) begin
        miss_next = miss_reg + 8'h01;
      end
      case (state_reg)
        cgis_pkg::CG_OFF: begin
          edges_next = 4'h0;
          if (css_option_i) begin
            state_next = cgis_pkg::CG_MAIN;
          end
        end
        cgis_pkg::CG_MAIN: begin
          edges_next = 4'h0;
          if (!css_option_i) begin
            state_next = cgis_pkg::CG_OFF;
          end else if (main_dead) begin
            state_next = cgis_pkg::CG_SAFE;
          end
        end
        cgis_pkg::CG_SAFE: begin
          if (!css_option_i) begin
            state_next = cgis_pkg::CG_OFF;
          end else if (main_dead) begin
            edges_next = 4'h0;
          end else if (main_edge) begin
            edges_next = edges_reg + 4'h1;
            if (edges_next == cgis_pkg::RECOVER_EDGES) begin
              state_next = cgis_pkg::CG_MAIN;
              edges_next = 4'h0;
            end
          end
        end
        default: begin
          state_next = cgis_pkg::CG_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= cgis_pkg::CG_OFF;
      miss_reg <= 8'h00;
      edges_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      miss_reg <= miss_next;
      edges_reg <= edges_next;
    end
  end

  cgis_clk_switch u_switch (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .main_lvl_i(filt_reg),
    .safe_lvl_i(lvl_reg[cgis_pkg::SY_SAFE]),
    .use_safe_i(state_reg == cgis_pkg::CG_SAFE),
    .main_dead_i(main_dead),
    .stop_i(halt_i),
    .clk_o(clk_lvl),
    .on_safe_o(on_safe)
  );

  // ------------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------------
  // Writes and read side effects happen at the acknowledge edge, the
  // one edge at which the master is known to hold a stable request.
  always_comb begin
    bus_take = wb_cyc_i & wb_stb_i & ack_reg;
    hit = wb_adr_i == cgis_pkg::ICS_ADDR;
    wr_take = bus_take & wb_we_i & wb_sel_i & hit & ~halt_i;
    rd_take = bus_take & ~wb_we_i & hit & ~halt_i;
    wdat = cgis_pkg::cgis_ics_t'(wb_dat_i);
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    dat_next = dat_reg;
    if (ack_next) begin
      dat_next = hit ? ics_reg : cgis_pkg::UNMAPPED_DATA;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 8'h00;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // ------------------------------------------------------------------
  // Integrity control/status register
  // ------------------------------------------------------------------
  always_comb begin
    ics_next = ics_reg;
    pend_next = pend_reg;
    supply_sel = ics_reg.monitor_source_select ?
      lvl_reg[cgis_pkg::SY_PIN] : lvl_reg[cgis_pkg::SY_VDD];
    toggle = 1'b0;
    ie_rise = 1'b0;
    if (!halt_i) begin
      if (wr_take) begin
        ics_next.monitor_source_select = wdat.monitor_source_select;
        ics_next.supply_monitor_irq_enable = wdat.supply_monitor_irq_enable;
        ics_next.clock_fail_irq_enable = wdat.clock_fail_irq_enable;
      end
      ics_next.supply_monitor_flag = lvd_option_i & supply_sel;
      toggle = ics_next.supply_monitor_flag != ics_reg.supply_monitor_flag;
      ie_rise = ics_next.supply_monitor_irq_enable &
        ~ics_reg.supply_monitor_irq_enable & ics_reg.supply_monitor_flag;
      // Safe flag: set while on the safe clock, so a set beats a read.
      if (!css_option_i) begin
        ics_next.safe_clock_active_flag = 1'b0;
      end else if (on_safe) begin
        ics_next.safe_clock_active_flag = 1'b1;
      end else if (rd_take && state_reg != cgis_pkg::CG_SAFE) begin
        ics_next.safe_clock_active_flag = 1'b0;
      end
    end
    if (supply_irq_ack_i) begin
      pend_next = 1'b0;
    end
    if ((toggle | ie_rise) & ics_next.supply_monitor_irq_enable & lvd_option_i) begin
      pend_next = 1'b1;
    end
    if (wr_take && !wdat.undervoltage_reset_flag) begin
      ics_next.undervoltage_reset_flag = 1'b0;
    end
    if (wr_take && !wdat.watchdog_reset_flag) begin
      ics_next.watchdog_reset_flag = 1'b0;
    end
    // Pin and watchdog resets leave the undervoltage flag alone.
    if (wdg_reset_i) begin
      ics_next.watchdog_reset_flag = 1'b1;
    end
    if (lvd_reset_i) begin
      ics_next.undervoltage_reset_flag = 1'b1;
      ics_next.watchdog_reset_flag = 1'b0;
    end
    ics_next.reserved = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ics_reg <= cgis_pkg::cgis_ics_t'(cgis_pkg::ICS_RESET);
      pend_reg <= 1'b0;
    end else begin
      ics_reg <= ics_next;
      pend_reg <= pend_next;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt requests, wake-up and reset source
  // ------------------------------------------------------------------
  // Without the undervoltage option both flags carry no meaning; the
  // decode still runs and software must ignore it.
  always_comb begin
    cf_irq_next = ics_reg.safe_clock_active_flag & ics_reg.clock_fail_irq_enable &
      css_option_i & ~global_mask_i;
    sm_irq_next = pend_reg & ics_reg.supply_monitor_irq_enable &
      lvd_option_i & ~global_mask_i;
    wake_next = wait_i & ~halt_i & (cf_irq_next | sm_irq_next);
    if (ics_reg.undervoltage_reset_flag) begin
      src_next = cgis_pkg::SRC_UV;
    end else if (ics_reg.watchdog_reset_flag) begin
      src_next = cgis_pkg::SRC_WDG;
    end else begin
      src_next = cgis_pkg::SRC_PIN;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cf_irq_reg <= 1'b0;
      sm_irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      src_reg <= cgis_pkg::SRC_PIN;
      proc_clk_reg <= 1'b0;
      safe_en_reg <= 1'b0;
      safe_act_reg <= 1'b0;
    end else begin
      cf_irq_reg <= cf_irq_next;
      sm_irq_reg <= sm_irq_next;
      wake_reg <= wake_next;
      src_reg <= src_next;
      proc_clk_reg <= clk_lvl & ~halt_i;
      safe_en_reg <= css_option_i & ~halt_i;
      safe_act_reg <= on_safe;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign processor_clock_o = proc_clk_reg;
  assign safe_osc_enable_o = safe_en_reg;
  assign safe_clock_active_o = safe_act_reg;
  assign clock_fail_irq_o = cf_irq_reg;
  assign supply_irq_o = sm_irq_reg;
  assign wake_o = wake_reg;
  assign reset_source_o = src_reg;

endmodule

`default_nettype wire

// ---- test/cgis_osc_model.sv ----
// Behavioural main oscillator that can run, stop and show single spikes.
`timescale 1ns/1ps
`default_nettype none

module cgis_osc_model #(
  parameter int HALF = 8
) (
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic spike_i,
  output logic osc_o
);
  // A broken resonator sticks at its last level, so a loss shows no edge at all.
  logic lvl_reg = 1'b0;
  int cnt_reg = 0;

  always @(posedge sys_clk_i) begin
    if (run_i) begin
      if (cnt_reg == HALF - 1) begin
        cnt_reg <= 0;
        lvl_reg <= ~lvl_reg;
      end else begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end

  assign osc_o = lvl_reg ^ spike_i;
endmodule

`default_nettype wire

// ---- test/cgis_assertions.sv ----
// Concurrent checks on the ports of the clock guard and integrity status block.
`timescale 1ns/1ps
`default_nettype none

module cgis_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [1:0] wb_adr_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic css_option_i,
  input wire logic lvd_option_i,
  input wire logic halt_i,
  input wire logic wait_i,
  input wire logic global_mask_i,
  input wire logic wdg_reset_i,
  input wire logic lvd_reset_i,
  input wire logic processor_clock_o,
  input wire logic safe_osc_enable_o,
  input wire logic safe_clock_active_o,
  input wire logic clock_fail_irq_o,
  input wire logic supply_irq_o,
  input wire logic wake_o,
  input wire logic [1:0] reset_source_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus access not answered by one ack pulse");
  reserved_zero_a: assert property (wb_ack_o && $past(!wb_we_i) |-> !wb_dat_o[3])
    else $error("reserved bit read as one");
  unmapped_a: assert property (wb_ack_o && $past(wb_adr_i != cgis_pkg::ICS_ADDR)
    |-> wb_dat_o == cgis_pkg::UNMAPPED_DATA)
    else $error("unmapped read returned data");
  guard_off_a: assert property (wb_ack_o && $past(!wb_we_i && !css_option_i) |-> !wb_dat_o[1])
    else $error("clock fail flag set with guard off");
  flag_set_a: assert property (wb_ack_o && $past(!wb_we_i && css_option_i) &&
    $past(safe_clock_active_o, 2) |-> wb_dat_o[1])
    else $error("clock fail flag clear on safe clock");
  halt_freeze_a: assert property (halt_i |=> !processor_clock_o && !safe_osc_enable_o)
    else $error("clock or safe oscillator active in halt");
  fail_gate_a: assert property (global_mask_i || !css_option_i |=> !clock_fail_irq_o)
    else $error("clock fail interrupt while gated");
  supply_gate_a: assert property (global_mask_i || !lvd_option_i |=> !supply_irq_o)
    else $error("supply interrupt while gated");
  wake_rel_a: assert property (wake_o == ($past(wait_i && !halt_i) &&
    (clock_fail_irq_o || supply_irq_o)))
    else $error("wake request mismatch");
  uv_source_a: assert property (lvd_reset_i |-> ##2 reset_source_o == cgis_pkg::SRC_UV)
    else $error("undervoltage source not reported");
  wdg_source_a: assert property (wdg_reset_i |-> ##2 reset_source_o != cgis_pkg::SRC_PIN)
    else $error("watchdog reset reported as pin reset");

  cover property (safe_clock_active_o && clock_fail_irq_o);
  cover property (supply_irq_o && wake_o);
  cover property (wb_ack_o && reset_source_o == cgis_pkg::SRC_UV);
endmodule

`default_nettype wire

// ---- test/tb_cgis_top.sv ----
// Self-checking bench for the clock guard and integrity status block.
`timescale 1ns/1ps
`default_nettype none

module tb_cgis_top;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1;
  logic [1:0] adr = 2'h0;
  logic [7:0] dat = 8'h00;
  logic vdd = 1'b0, pin = 1'b0, pll = 1'b1, clock_guard = 1'b1, undervoltage_detector = 1'b1, halt = 1'b0;
  logic wt = 1'b0, mask = 1'b0, sack = 1'b0, ext = 1'b0, wdg = 1'b0, lvdr = 1'b0;
  logic run = 1'b1, spike = 1'b0;
  logic main, safe, ack, pclk, sen, sact, cfi, sui, wake;
  logic [7:0] dat_o;
  logic [1:0] src;
  int n_mismatch = 0, n_tests = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  cgis_osc_model #(.HALF(8)) u_cgis_osc_model (.sys_clk_i(sys_clk_i), .run_i(run),
    .spike_i(spike), .osc_o(main));
  cgis_osc_model #(.HALF(20)) u_cgis_osc_model_safe (.sys_clk_i(sys_clk_i), .run_i(1'b1),
    .spike_i(1'b0), .osc_o(safe));
  cgis_top u_cgis_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .main_osc_i(main), .safe_osc_i(safe), .supply_cmp_vdd_i(vdd),
    .supply_cmp_pin_i(pin), .pll_enable_i(pll), .css_option_i(clock_guard), .lvd_option_i(undervoltage_detector),
    .halt_i(halt), .wait_i(wt), .global_mask_i(mask), .supply_irq_ack_i(sack),
    .ext_reset_i(ext), .wdg_reset_i(wdg), .lvd_reset_i(lvdr), .processor_clock_o(pclk),
    .safe_osc_enable_o(sen), .safe_clock_active_o(sact), .clock_fail_irq_o(cfi),
    .supply_irq_o(sui), .wake_o(wake), .reset_source_o(src));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_o;
    chk("bus ack", 8'h01, {7'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, cgis_pkg::ICS_ADDR, 8'h00, q);
    chk(nm, e, q);
  endtask

  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, cgis_pkg::ICS_ADDR, d, q);
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge sys_clk_i);
    {ext, wdg, lvdr} <= m;
    @(posedge sys_clk_i);
    {ext, wdg, lvdr} <= 3'h0;
    step(2);
  endtask

  task automatic wait_safe(input logic want);
    int n;
    n = 0;
    while (sact !== want && n < 400) begin
      step(1);
      n++;
    end
  endtask

  task automatic toggles(input int n, output int c);
    logic p;
    c = 0;
    p = pclk;
    repeat (n) begin
      step(1);
      if (pclk !== p) c++;
      p = pclk;
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] q;
    rd_chk("reset value", cgis_pkg::ICS_RESET);
    chk("pin source", {6'h0, cgis_pkg::SRC_PIN}, {6'h0, src});
    wr(8'hc4);
    rd_chk("writable bits", 8'hc4);
    sel <= 1'b0;
    wr(8'h00);
    sel <= 1'b1;
    rd_chk("masked write", 8'hc4);
    bus(1'b1, 2'h1, 8'hff, q);
    bus(1'b0, 2'h1, 8'h00, q);
    chk("unmapped", cgis_pkg::UNMAPPED_DATA, q);
    wr(8'h00);
  endtask

  task automatic t_resets();
    pulse(3'b010);
    rd_chk("watchdog flag", 8'h01);
    chk("wdg source", {6'h0, cgis_pkg::SRC_WDG}, {6'h0, src});
    pulse(3'b001);
    rd_chk("uv flag", 8'h10);
    pulse(3'b010);
    pulse(3'b100);
    rd_chk("uv kept", 8'h11);
    chk("uv source", {6'h0, cgis_pkg::SRC_UV}, {6'h0, src});
    wr(8'h01);
    rd_chk("uv cleared", 8'h01);
    chk("wdg source", {6'h0, cgis_pkg::SRC_WDG}, {6'h0, src});
    wr(8'h00);
    rd_chk("wdg cleared", 8'h00);
  endtask

  task automatic t_supply();
    wr(8'h40);
    vdd <= 1'b1;
    step(8);
    chk("supply irq", 8'h01, {7'h0, sui});
    rd_chk("supply flag", 8'h60);
    wt <= 1'b1;
    step(3);
    chk("wake", 8'h01, {7'h0, wake});
    wt <= 1'b0;
    sack <= 1'b1;
    step(1);
    sack <= 1'b0;
    step(2);
    chk("irq served", 8'h00, {7'h0, sui});
    mask <= 1'b1;
    vdd <= 1'b0;
    step(8);
    chk("masked irq", 8'h00, {7'h0, sui});
    mask <= 1'b0;
    step(3);
    chk("falling toggle", 8'h01, {7'h0, sui});
    sack <= 1'b1;
    step(1);
    sack <= 1'b0;
    wr(8'h80);
    pin <= 1'b1;
    step(8);
    rd_chk("pin selected", 8'ha0);
    pin <= 1'b0;
    wr(8'h00);
    undervoltage_detector <= 1'b0;
    vdd <= 1'b1;
    step(8);
    rd_chk("detector off", 8'h00);
    vdd <= 1'b0;
    undervoltage_detector <= 1'b1;
    step(8);
  endtask

  task automatic t_clock();
    int c;
    wr(8'h04);
    // Two-cycle spikes every 31 cycles pass the pin voting and would hide
    // the loss if they got past the filter.
    run <= 1'b0;
    repeat (4) begin
      step(29);
      spike <= 1'b1;
      step(2);
      spike <= 1'b0;
    end
    wait_safe(1'b1);
    chk("on safe", 8'h01, {7'h0, sact});
    step(3);
    chk("fail irq", 8'h01, {7'h0, cfi});
    toggles(120, c);
    chk("safe clock runs", 8'h01, {7'h0, c > 0});
    rd_chk("fail flag", 8'h06);
    rd_chk("held on safe", 8'h06);
    run <= 1'b1;
    wait_safe(1'b0);
    chk("back on main", 8'h00, {7'h0, sact});
    rd_chk("read clears", 8'h06);
    rd_chk("after clear", 8'h04);
    halt <= 1'b1;
    step(3);
    chk("safe osc off", 8'h00, {7'h0, sen});
    toggles(60, c);
    chk("clock stopped", 8'h00, {7'h0, c > 0});
    wr(8'h00);
    rd_chk("frozen", 8'h04);
    halt <= 1'b0;
    step(3);
    chk("guard resumed", 8'h01, {7'h0, sen});
    clock_guard <= 1'b0;
    run <= 1'b0;
    step(150);
    rd_chk("guard off", 8'h04);
    chk("no fail irq", 8'h00, {7'h0, cfi});
    run <= 1'b1;
    clock_guard <= 1'b1;
    wr(8'h00);
  endtask

  initial begin
    step(20);
    rst_i <= 1'b0;
    t_regs();
    t_resets();
    t_supply();
    t_clock();
    conclude();
  end

  // The tests need about 750 cycles, so this limit only cuts a hang.
  initial begin
    step(20000);
    n_mismatch++;
    conclude();
  end
endmodule

bind cgis_top cgis_assertions u_cgis_assertions (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .css_option_i(css_option_i),
  .lvd_option_i(lvd_option_i), .halt_i(halt_i), .wait_i(wait_i),
  .global_mask_i(global_mask_i), .wdg_reset_i(wdg_reset_i), .lvd_reset_i(lvd_reset_i),
  .processor_clock_o(processor_clock_o), .safe_osc_enable_o(safe_osc_enable_o),
  .safe_clock_active_o(safe_clock_active_o), .clock_fail_irq_o(clock_fail_irq_o),
  .supply_irq_o(supply_irq_o), .wake_o(wake_o), .reset_source_o(reset_source_o));

`default_nettype wire
